// ---- pmx_exec.sv ----
// executor for accumulator pair moves and indirect data memory stores
`timescale 1ns/1ns
`include "pmx_consts.svh"
module pmx_exec (
  input wire logic clock,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic [7:0] work_reg_zero,
  input wire logic [7:0] work_reg_one,
  input wire logic [7:0] pair0_high_reg,
  input wire logic [7:0] pair1_high_reg,
  input wire pmx_pkg::pmx_pair_t accumulator_in,
  output pmx_pkg::pmx_pair_t accumulator_pair,
  output logic upper_accumulator_flag,
  output logic acc_load,
  output logic pair_store,
  output pmx_pkg::pmx_pair_t pair_store_data,
  output logic pair_store_sel,
  output pmx_pkg::pmx_mem_wr_t mem_wr,
  output logic busy
);
  import pmx_pkg::*;

  // opcode class, decoded whatever the state
  logic op_ptr;
  logic [7:0] op_masked;
  logic hit_store_ind;
  logic hit_store_imm;
  logic hit_load_long;
  logic hit_store_long;

  // classes gated by the sequencer
  logic take_op;
  logic take_imm;
  logic is_store_ind;
  logic is_store_imm;
  logic is_load_long;
  logic is_store_long;

  // register pairs and pointers
  pmx_pair_t pair0_view;
  pmx_pair_t pair1_view;
  logic [7:0] ptr_now;
  logic [7:0] ptr_held;

  // sequencer
  pmx_state_t state_q;
  pmx_state_t state_d;
  logic ptr_sel_q;
  logic ptr_sel_d;

  // accumulator pair load
  pmx_pair_t acc_q;
  pmx_pair_t acc_d;
  logic flag_q;
  logic flag_d;
  logic load_q;
  logic load_d;

  // register pair store
  logic pst_q;
  logic pst_d;
  logic psel_q;
  logic psel_d;
  pmx_pair_t pdata_q;
  pmx_pair_t pdata_d;

  // data memory write
  pmx_mem_wr_t wr_q;
  pmx_mem_wr_t wr_d;

  always_comb begin
    op_ptr = op_byte[`PMX_PTR_BIT];
    op_masked = op_byte & `PMX_OP_MASK_PTR;
    hit_store_ind = (op_masked == `PMX_OP_STORE_IND);
    hit_store_imm = (op_masked == `PMX_OP_STORE_IMM);
    hit_load_long = (op_masked == `PMX_OP_LOAD_LONG);
    hit_store_long = (op_masked == `PMX_OP_STORE_LONG);
  end

  // gating keeps an immediate byte from being decoded as an opcode
  always_comb begin
    take_op = op_valid && (state_q == PMX_IDLE);
    take_imm = op_valid && (state_q == PMX_IMM);
    // unknown opcodes match none of these and leave no trace
    is_store_ind = take_op && hit_store_ind;
    is_store_imm = take_op && hit_store_imm;
    is_load_long = take_op && hit_load_long;
    is_store_long = take_op && hit_store_long;
  end

  always_comb begin
    pair0_view.high = pair0_high_reg;
    pair0_view.low = work_reg_zero;
    pair1_view.high = pair1_high_reg;
    pair1_view.low = work_reg_one;
  end

  always_comb begin
    ptr_now = op_ptr ? work_reg_one : work_reg_zero;
    // read late, so a pointer update during the stall is honoured
    ptr_held = ptr_sel_q ? work_reg_one : work_reg_zero;
  end

  always_comb begin
    state_d = state_q;
    ptr_sel_d = ptr_sel_q;
    unique case (state_q)
      PMX_IDLE: begin
        if (is_store_imm) begin
          ptr_sel_d = op_ptr;
          state_d = PMX_IMM;
        end
      end
      PMX_IMM: begin
        // the fetch may take any number of cycles to deliver the byte
        if (take_imm) begin
          state_d = PMX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= PMX_IDLE;
      ptr_sel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_sel_q <= ptr_sel_d;
    end
  end

  always_comb begin
    acc_d = acc_q;
    flag_d = flag_q;
    load_d = 1'b0;
    if (is_load_long) begin
      load_d = 1'b1;
      // flag follows the loaded upper byte
      if (op_ptr) begin
        acc_d = pair1_view;
        flag_d = |pair1_view.high;
      end else begin
        acc_d = pair0_view;
        flag_d = |pair0_view.high;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_q <= `PMX_PAIR_RST;
      flag_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      flag_q <= flag_d;
      load_q <= load_d;
    end
  end

  always_comb begin
    // pulse only; select and data hold until the next store
    pst_d = 1'b0;
    psel_d = psel_q;
    pdata_d = pdata_q;
    if (is_store_long) begin
      pst_d = 1'b1;
      psel_d = op_ptr;
      pdata_d = accumulator_in;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pst_q <= 1'b0;
      psel_q <= 1'b0;
      pdata_q <= `PMX_PAIR_RST;
    end else begin
      pst_q <= pst_d;
      psel_q <= psel_d;
      pdata_q <= pdata_d;
    end
  end

  always_comb begin
    wr_d.en = 1'b0;
    wr_d.addr = `PMX_BYTE_RST;
    wr_d.data = `PMX_BYTE_RST;
    if (is_store_ind) begin
      wr_d.en = 1'b1;
      wr_d.addr = ptr_now;
      wr_d.data = accumulator_in.low;
    end else if (take_imm) begin
      wr_d.en = 1'b1;
      wr_d.addr = ptr_held;
      wr_d.data = op_byte;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q.en <= 1'b0;
      wr_q.addr <= `PMX_BYTE_RST;
      wr_q.data <= `PMX_BYTE_RST;
    end else begin
      wr_q <= wr_d;
    end
  end

  assign accumulator_pair = acc_q;
  assign upper_accumulator_flag = flag_q;
  assign acc_load = load_q;
  assign pair_store = pst_q;
  assign pair_store_sel = psel_q;
  assign pair_store_data = pdata_q;
  assign mem_wr = wr_q;
  assign busy = (state_q == PMX_IMM);
endmodule

// ---- pmx_consts.svh ----
// constants for the pair move instruction executor
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH
`define PMX_OP_STORE_IND 8'hA0
`define PMX_OP_STORE_IMM 8'hB0
`define PMX_OP_LOAD_LONG 8'h98
`define PMX_OP_STORE_LONG 8'h88
`define PMX_OP_MASK_PTR 8'hFE
`define PMX_PTR_BIT 0
`define PMX_BYTE_RST 8'h00
`define PMX_PAIR_RST 16'h0000
`endif

// ---- pmx_pkg.sv ----
// types for the pair move instruction executor
package pmx_pkg;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } pmx_pair_t;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } pmx_mem_wr_t;
  typedef enum logic {
    PMX_IDLE,
    PMX_IMM
  } pmx_state_t;
endpackage

// ---- pmx_exec_monitor.sv ----
// checker for the pair move executor
`timescale 1ns/1ns
module pmx_exec_chk (
  input logic clock,
  input logic srst,
  input logic op_valid,
  input logic [7:0] op_byte,
  input logic [7:0] work_reg_zero,
  input logic [7:0] work_reg_one,
  input logic [7:0] pair0_high_reg,
  input logic [7:0] pair1_high_reg,
  input pmx_pkg::pmx_pair_t accumulator_in,
  input pmx_pkg::pmx_pair_t accumulator_pair,
  input logic upper_accumulator_flag,
  input logic acc_load,
  input logic pair_store,
  input logic pair_store_sel,
  input pmx_pkg::pmx_pair_t pair_store_data,
  input pmx_pkg::pmx_mem_wr_t mem_wr,
  input logic busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire go = op_valid && !busy;
  sequence ind_op; go && op_byte[7:1] == 7'h50; endsequence
  sequence imm_op; go && op_byte[7:1] == 7'h58; endsequence
  sequence imm; imm_op ##1 op_valid; endsequence
  property ind_lands;
    ind_op |=> mem_wr.en && mem_wr.data == $past(accumulator_in.low)
      && mem_wr.addr == ($past(op_byte[0]) ? $past(work_reg_one) : $past(work_reg_zero));
  endproperty
  property imm_lands;
    imm |=> mem_wr.en && mem_wr.data == $past(op_byte)
      && mem_wr.addr == ($past(op_byte[0], 2) ? $past(work_reg_one) : $past(work_reg_zero));
  endproperty
  property load_zero;
    go && op_byte == 8'h98 |=> acc_load && !mem_wr.en
      && accumulator_pair == {$past(pair0_high_reg), $past(work_reg_zero)};
  endproperty
  property load_one;
    go && op_byte == 8'h99 |=> acc_load
      && accumulator_pair == {$past(pair1_high_reg), $past(work_reg_one)};
  endproperty
  property pair_moves;
    go && op_byte[7:1] == 7'h44 |=> pair_store && pair_store_sel == $past(op_byte[0])
      && pair_store_data == $past(accumulator_in);
  endproperty
  chk_ind_store: assert property (ind_lands)
    else $error("indirect store wrong");
  chk_imm_store: assert property (imm_lands)
    else $error("immediate store wrong");
  chk_load_zero: assert property (load_zero)
    else $error("pair zero load wrong");
  chk_load_one: assert property (load_one)
    else $error("pair one load wrong");
  chk_flag_high: assert property (acc_load |-> upper_accumulator_flag == |accumulator_pair.high)
    else $error("flag wrong");
  chk_pair_store: assert property (pair_moves)
    else $error("pair store wrong");
  chk_stray_write: assert property (!op_valid |=> !mem_wr.en)
    else $error("write without request");
endmodule

// ---- tb_pair_move_instruction_exec.sv ----
// bench for the pair move executor
`timescale 1ns/1ns
`define C(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch %0t: value differs", $time); end end
module tb_pair_move_instruction_exec;
  import pmx_pkg::*;
  logic clock = 1'b0, srst = 1'b1, op_valid = 1'b0, upper_accumulator_flag, acc_load, busy, pair_store, pair_store_sel;
  logic [7:0] op_byte = 8'h00, work_reg_zero = 8'h03, work_reg_one = 8'h09, pair0_high_reg = 8'h00;
  logic [7:0] pair1_high_reg = 8'h05;
  pmx_pair_t accumulator_in = 16'h1234, accumulator_pair, pair_store_data;
  pmx_mem_wr_t mem_wr;
  int err_total = 0, n_compared = 0;
  always #2 clock = ~clock;
  pmx_exec dut (
    .clock(clock), .srst(srst), .op_valid(op_valid), .op_byte(op_byte),
    .work_reg_zero(work_reg_zero), .work_reg_one(work_reg_one),
    .pair0_high_reg(pair0_high_reg), .pair1_high_reg(pair1_high_reg),
    .accumulator_in(accumulator_in), .accumulator_pair(accumulator_pair),
    .upper_accumulator_flag(upper_accumulator_flag), .acc_load(acc_load),
    .pair_store(pair_store), .pair_store_sel(pair_store_sel), .pair_store_data(pair_store_data),
    .mem_wr(mem_wr), .busy(busy)
  );
  task step(input logic [8:0] vb);
    {op_valid, op_byte} = vb;
    @(posedge clock) #1;
  endtask
  task t_ind(input int r);
    step(9'h1A0 + 9'(r));
    `C(mem_wr, {1'b1, r ? work_reg_one : work_reg_zero, accumulator_in.low})
    $display("ind done");
  endtask
  // immediate store, data byte late when r is one
  task t_imm(input int r);
    step(9'h1B0 + 9'(r));
    `C(busy, 1'b1)
    if (r) step(9'h000);
    step(9'h177);
    `C(mem_wr, {1'b1, r ? work_reg_one : work_reg_zero, 8'h77})
    $display("imm done");
  endtask
  task t_load(input int r);
    step(9'h198 + 9'(r));
    `C(accumulator_pair, {r ? pair1_high_reg : pair0_high_reg, r ? work_reg_one : work_reg_zero})
    `C({acc_load, upper_accumulator_flag}, {1'b1, |(r ? pair1_high_reg : pair0_high_reg)})
    $display("load done");
  endtask
  task t_store(input int r);
    step(9'h188 + 9'(r));
    `C({pair_store, pair_store_sel, pair_store_data}, {1'b1, r[0], accumulator_in})
    $display("store done");
  endtask
  // reset in mid stall, then an unknown opcode
  task t_reset();
    step(9'h1B0);
    srst = 1'b1;
    step(9'h000);
    srst = 1'b0;
    `C({busy, acc_load, pair_store, mem_wr.en}, 4'h0)
    step(9'h155);
    `C(mem_wr.en, 1'b0)
    $display("reset done");
  endtask
  task print_verdict();
    $display("%0d compared %0d mismatches", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1 srst = 0;
    // back to back opcodes on purpose
    for (int r = 1; r >= 0; r--) begin
      t_ind(r);
      t_imm(r);
      t_load(r);
      t_store(r);
    end
    t_reset();
    print_verdict();
  end
endmodule
bind pmx_exec pmx_exec_chk chk (
  .clock(clock), .srst(srst), .op_valid(op_valid), .op_byte(op_byte),
  .work_reg_zero(work_reg_zero), .work_reg_one(work_reg_one),
  .pair0_high_reg(pair0_high_reg), .pair1_high_reg(pair1_high_reg),
  .accumulator_in(accumulator_in), .accumulator_pair(accumulator_pair),
  .upper_accumulator_flag(upper_accumulator_flag), .acc_load(acc_load),
  .pair_store(pair_store), .pair_store_sel(pair_store_sel), .pair_store_data(pair_store_data),
  .mem_wr(mem_wr), .busy(busy)
);
